// file: core/scr_consts.svh
/*
  Offsets, field positions, reset values and fixed figures of the sensor
  control register bank.
  Assumes it is included by bare name, before any code that uses it.
*/
`ifndef SCR_CONSTS_SVH
`define SCR_CONSTS_SVH

// ==========================================================================
// Register offsets on the local register port
`define SCR_OFS_MEAS_CFG      2'h0
`define SCR_OFS_HEATER_CFG    2'h1
`define SCR_OFS_IRQ_STATUS    2'h2
`define SCR_OFS_IRQ_MASK      2'h3

// ==========================================================================
// Field positions of measurement_config
`define SCR_BIT_RES_HI        7
`define SCR_BIT_SUPPLY_LOW    6
`define SCR_BIT_HEATER_EN     2
`define SCR_BIT_RES_LO        0
`define SCR_MEAS_RESERVED_FIELD_MASK    8'h3A

// Field positions of heater_level_config
`define SCR_HEATER_LVL_HI     3
`define SCR_HEATER_LVL_LO     0

// ==========================================================================
// Reset values
`define SCR_RST_MEAS_CFG      8'h3A
`define SCR_RST_HEATER_CFG    8'h00
`define SCR_RST_IRQ_MASK      3'h0

// Interrupt status bit positions
`define SCR_EV_SUPPLY_LOW     0
`define SCR_EV_HEATER_CHANGE  1
`define SCR_EV_RES_CHANGE     2
`define SCR_EV_COUNT          3

// Answer to a read of an unmapped offset
`define SCR_UNMAPPED_READ     8'h00

// Result widths per resolution code
`define SCR_RH_W_00           4'hC
`define SCR_TEMP_W_00         4'hE
`define SCR_RH_W_01           4'h8
`define SCR_TEMP_W_01         4'hC
`define SCR_RH_W_10           4'hA
`define SCR_TEMP_W_10         4'hD
`define SCR_RH_W_11           4'hB
`define SCR_TEMP_W_11         4'hB

`endif

// file: core/scr_pkg.sv
/*
  Types shared by the sensor control register bank.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package scr_pkg;

  // ========================================================================
  // Register selection decoded from the address
  typedef enum logic [2:0] {
    SCR_SEL_MEAS,
    SCR_SEL_HEATER,
    SCR_SEL_IRQ_STATUS,
    SCR_SEL_IRQ_MASK,
    SCR_SEL_NONE
  } scr_sel_t;

  // Byte carried by the register port
  typedef logic [7:0] scr_byte_t;

  // Two-bit measurement resolution code
  typedef logic [1:0] scr_res_t;

  // Result width in bits
  typedef logic [3:0] scr_width_t;

endpackage

`default_nettype wire

// file: core/scr_supply_sync.sv
/*
  Three-stage synchroniser with agreement filter for the supply monitor.
  Assumes the input comes from an analog comparator outside clk_sys.
*/
`default_nettype none

module scr_supply_sync (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic asyncIn,
  output var  logic levelOut
);

  // ========================================================================
  // Synchroniser chain
  logic stage1_r;
  logic stage2_r;
  logic stage3_r;

  // Stage one feeds stage two only, to keep metastability contained
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stage1_r <= 1'b0;
      stage2_r <= 1'b0;
      stage3_r <= 1'b0;
    end else begin
      stage1_r <= asyncIn;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
    end
  end

  // ========================================================================
  // Level changes only once stages two and three agree
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      levelOut <= 1'b0;
    end else if (stage2_r == stage3_r) begin
      levelOut <= stage3_r;
    end
  end

endmodule

`default_nettype wire

// file: core/scr_regs.sv
/*
  Sensor control register bank: measurement configuration, heater level,
  supply-low status and an interrupt status and mask pair.
  Assumes a single-master register port in the clk_sys domain and an
  asynchronous supply monitor level on supplyLowIn.
*/
`include "scr_consts.svh"
`default_nettype none

module scr_regs #(
  parameter int ADDR_W = 2
) (
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [7:0]        regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output var  logic [7:0]        regRdata,
  input  wire logic              supplyLowIn,
  output var  logic [1:0]        resolutionSelect,
  output var  logic [3:0]        rhWidth,
  output var  logic [3:0]        tempWidth,
  output var  logic              heaterOn,
  output var  logic [3:0]        heaterDrive,
  output var  logic              irq
);

  // ========================================================================
  // Elaboration checks
  if (ADDR_W < 2) begin : gAddrCheck
    $error("scr_regs: ADDR_W must be at least 2");
  end

  // Status bits must fit the byte read back
  if (`SCR_EV_COUNT > 8) begin : gEvCheck
    $error("scr_regs: event count exceeds the status byte");
  end

  // ========================================================================
  // Decoding functions

  // Address to register selection
  function automatic scr_pkg::scr_sel_t decodeSel(
    input logic [ADDR_W-1:0] addr
  );
    scr_pkg::scr_sel_t sel;
    sel = scr_pkg::SCR_SEL_NONE;
    if (addr == ADDR_W'(`SCR_OFS_MEAS_CFG)) begin
      sel = scr_pkg::SCR_SEL_MEAS;
    end else if (addr == ADDR_W'(`SCR_OFS_HEATER_CFG)) begin
      sel = scr_pkg::SCR_SEL_HEATER;
    end else if (addr == ADDR_W'(`SCR_OFS_IRQ_STATUS)) begin
      sel = scr_pkg::SCR_SEL_IRQ_STATUS;
    end else if (addr == ADDR_W'(`SCR_OFS_IRQ_MASK)) begin
      sel = scr_pkg::SCR_SEL_IRQ_MASK;
    end
    return sel;
  endfunction

  // Humidity result width for a resolution code
  function automatic scr_pkg::scr_width_t rhWidthOf(
    input scr_pkg::scr_res_t res
  );
    scr_pkg::scr_width_t w;
    w = `SCR_RH_W_00;
    unique case (res)
      2'h0: w = `SCR_RH_W_00;
      2'h1: w = `SCR_RH_W_01;
      2'h2: w = `SCR_RH_W_10;
      2'h3: w = `SCR_RH_W_11;
    endcase
    return w;
  endfunction

  // Temperature result width for a resolution code
  function automatic scr_pkg::scr_width_t tempWidthOf(
    input scr_pkg::scr_res_t res
  );
    scr_pkg::scr_width_t w;
    w = `SCR_TEMP_W_00;
    unique case (res)
      2'h0: w = `SCR_TEMP_W_00;
      2'h1: w = `SCR_TEMP_W_01;
      2'h2: w = `SCR_TEMP_W_10;
      2'h3: w = `SCR_TEMP_W_11;
    endcase
    return w;
  endfunction

  // Resolution code held in bits 7 and 0 of a configuration byte
  function automatic scr_pkg::scr_res_t resFieldOf(
    input scr_pkg::scr_byte_t b
  );
    return {b[`SCR_BIT_RES_HI], b[`SCR_BIT_RES_LO]};
  endfunction

  // ========================================================================
  // Declarations
  scr_pkg::scr_sel_t          accSel;
  logic                       resHi_r;
  logic                       resLo_r;
  logic                       heaterEn_r;
  logic [7:0]                 heaterCfg_r;
  logic [`SCR_EV_COUNT-1:0]   irqMask_r;
  logic [`SCR_EV_COUNT-1:0]   irqStatus_r;
  logic [`SCR_EV_COUNT-1:0]   evPulse;
  logic                       supplyLow;
  logic                       supplyLowPrev_r;
  logic                       measWr;
  logic                       heaterWr;
  logic                       maskWr;
  logic                       statusRd;
  logic [7:0]                 measView;
  logic [7:0]                 readVal;
  scr_pkg::scr_res_t          resNow;

  // ========================================================================
  // Supply monitor crossing
  scr_supply_sync uSupplySync (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .asyncIn  (supplyLowIn),
    .levelOut (supplyLow)
  );

  // ========================================================================
  // Access decode
  assign accSel   = decodeSel(regAddr);
  assign measWr   = regWr && (accSel == scr_pkg::SCR_SEL_MEAS);
  assign heaterWr = regWr && (accSel == scr_pkg::SCR_SEL_HEATER);
  assign maskWr   = regWr && (accSel == scr_pkg::SCR_SEL_IRQ_MASK);
  assign statusRd = regRd && (accSel == scr_pkg::SCR_SEL_IRQ_STATUS);
  assign resNow   = {resHi_r, resLo_r};

  // ========================================================================
  // Measurement configuration: resolution fields
  // Writes to unmapped offsets fall through here untouched
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      resHi_r <= 1'(`SCR_RST_MEAS_CFG >> `SCR_BIT_RES_HI);
      resLo_r <= 1'(`SCR_RST_MEAS_CFG >> `SCR_BIT_RES_LO);
    end else if (measWr) begin
      // Both resolution bits, 7 and 0, taken in one cycle
      {resHi_r, resLo_r} <= resFieldOf(regWdata);
    end
  end

  // Measurement configuration: heater enable
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      heaterEn_r <= 1'(`SCR_RST_MEAS_CFG >> `SCR_BIT_HEATER_EN);
    end else if (measWr) begin
      heaterEn_r <= regWdata[`SCR_BIT_HEATER_EN];
    end
  end

  // Read view: reserved bits forced high, supply flag from the monitor
  always_comb begin
    measView = `SCR_MEAS_RESERVED_FIELD_MASK;
    measView[`SCR_BIT_RES_HI]     = resHi_r;
    measView[`SCR_BIT_SUPPLY_LOW] = supplyLow;
    measView[`SCR_BIT_HEATER_EN]  = heaterEn_r;
    measView[`SCR_BIT_RES_LO]     = resLo_r;
  end

  // ========================================================================
  // Heater level configuration
  // Upper nibble is reserved but stored, so it reads back as written
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      heaterCfg_r <= `SCR_RST_HEATER_CFG;
    end else if (heaterWr) begin
      heaterCfg_r <= regWdata;
    end
  end

  // ========================================================================
  // Interrupt mask
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irqMask_r <= `SCR_RST_IRQ_MASK;
    end else if (maskWr) begin
      irqMask_r <= regWdata[`SCR_EV_COUNT-1:0];
    end
  end

  // ========================================================================
  // Event detection
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      supplyLowPrev_r <= 1'b0;
    end else begin
      supplyLowPrev_r <= supplyLow;
    end
  end

  // Supply drop, heater enable toggled, resolution changed by a write
  always_comb begin
    evPulse = '0;
    evPulse[`SCR_EV_SUPPLY_LOW] = supplyLow && !supplyLowPrev_r;
    evPulse[`SCR_EV_HEATER_CHANGE] =
      measWr && (regWdata[`SCR_BIT_HEATER_EN] != heaterEn_r);
    evPulse[`SCR_EV_RES_CHANGE] =
      measWr && (resFieldOf(regWdata) != resNow);
  end

  // ========================================================================
  // Sticky status bits, cleared by reading the status register
  // A new event in the clearing cycle keeps its bit set
  for (genvar i = 0; i < `SCR_EV_COUNT; i++) begin : gSticky
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        irqStatus_r[i] <= 1'b0;
      end else if (evPulse[i]) begin
        irqStatus_r[i] <= 1'b1;
      end else if (statusRd) begin
        irqStatus_r[i] <= 1'b0;
      end
    end
  end

  // Level interrupt from unmasked status
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStatus_r & irqMask_r);
    end
  end

  // ========================================================================
  // Read path
  always_comb begin
    readVal = `SCR_UNMAPPED_READ;
    unique case (accSel)
      scr_pkg::SCR_SEL_MEAS:       readVal = measView;
      scr_pkg::SCR_SEL_HEATER:     readVal = heaterCfg_r;
      scr_pkg::SCR_SEL_IRQ_STATUS: readVal = 8'(irqStatus_r);
      scr_pkg::SCR_SEL_IRQ_MASK:   readVal = 8'(irqMask_r);
      scr_pkg::SCR_SEL_NONE:       readVal = `SCR_UNMAPPED_READ;
    endcase
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      regRdata <= 8'h00;
    end else if (regRd) begin
      regRdata <= readVal;
    end else begin
      regRdata <= 8'h00;
    end
  end

  // ========================================================================
  // Measurement engine controls: resolution code
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      resolutionSelect <= 2'h0;
    end else begin
      resolutionSelect <= resNow;
    end
  end

  // Result widths for the current resolution code
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rhWidth   <= `SCR_RH_W_00;
      tempWidth <= `SCR_TEMP_W_00;
    end else begin
      rhWidth   <= rhWidthOf(resNow);
      tempWidth <= tempWidthOf(resNow);
    end
  end

  // ========================================================================
  // Heater energised only while the enable bit is set
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      heaterOn <= 1'b0;
    end else begin
      heaterOn <= heaterEn_r;
    end
  end

  // Heater drive: level passed on only while the heater is enabled
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      heaterDrive <= 4'h0;
    end else if (heaterEn_r) begin
      // Code maps straight to strength, 0 weakest, F strongest
      heaterDrive <=
        heaterCfg_r[`SCR_HEATER_LVL_HI:`SCR_HEATER_LVL_LO];
    end else begin
      heaterDrive <= 4'h0;
    end
  end

endmodule

`default_nettype wire

// file: verif/scr_regs_monitor.sv
/*
  Checker for the sensor control register bank, bound to its top module.
  Assumes the one-cycle register port and the output timing of scr_regs.
*/
`default_nettype none

module scr_regs_monitor #(
  parameter int ADDR_W = 2
) (
  input wire logic              clk_sys,
  input wire logic              rst_n,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [7:0]        regWdata,
  input wire logic              regWr,
  input wire logic              regRd,
  input wire logic [7:0]        regRdata,
  input wire logic              supplyLowIn,
  input wire logic [1:0]        resolutionSelect,
  input wire logic [3:0]        rhWidth,
  input wire logic [3:0]        tempWidth,
  input wire logic              heaterOn,
  input wire logic [3:0]        heaterDrive,
  input wire logic              irq
);
  // ========================================================================
  // Port timing relations, all in the clk_sys domain
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  AST_RDATA_IDLE: assert property (!regRd |=> regRdata == 8'h00)
    else $error("read data not zero outside a read answer");
  AST_RESET_VALS: assert property ($rose(rst_n) |-> rhWidth == 4'hC
    && tempWidth == 4'hE && !heaterOn && heaterDrive == 4'h0)
    else $error("outputs wrong after reset release");
  AST_WIDTH_01: assert property (resolutionSelect == 2'h1 |->
    rhWidth == 4'h8 && tempWidth == 4'hC)
    else $error("widths wrong for resolution 01");
  AST_WIDTH_11: assert property (resolutionSelect == 2'h3 |->
    rhWidth == 4'hB && tempWidth == 4'hB)
    else $error("widths wrong for resolution 11");
  AST_HEATER_GATE: assert property (!heaterOn |-> heaterDrive == 4'h0)
    else $error("heater driven while disabled");
  AST_WR_RES: assert property (regWr && regAddr == '0 |-> ##2
    resolutionSelect == {$past(regWdata[7], 2), $past(regWdata[0], 2)})
    else $error("resolution select not taken from bits 7 and 0");
  AST_WR_HTR_EN: assert property (regWr && regAddr == '0 |-> ##2
    heaterOn == $past(regWdata[2], 2))
    else $error("heater enable not taken from bit 2");
  AST_HTR_LEVEL: assert property ((regWr && regAddr == ADDR_W'(1)) ##1
    !(regWr && regAddr == '0) |=>
    heaterDrive == (heaterOn ? $past(regWdata[3:0], 2) : 4'h0))
    else $error("heater drive not the written level");
  AST_RESERVED_FIELD_ONES: assert property (regRd && regAddr == '0 |=>
    (regRdata & 8'h3A) == 8'h3A)
    else $error("reserved bits not read as one");
  AST_SUPPLY_FLAG: assert property ($stable(supplyLowIn)[*8] ##0
    (regRd && regAddr == '0) |=> regRdata[6] == $past(supplyLowIn))
    else $error("supply flag does not follow the monitor");
endmodule

bind scr_regs scr_regs_monitor #(.ADDR_W(ADDR_W)) scr_regs_monitor_inst (
  .clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
  .regRdata(regRdata), .supplyLowIn(supplyLowIn),
  .resolutionSelect(resolutionSelect), .rhWidth(rhWidth),
  .tempWidth(tempWidth), .heaterOn(heaterOn),
  .heaterDrive(heaterDrive), .irq(irq)
);

`default_nettype wire

// file: verif/scr_host_model.sv
/*
  Host controller model: master of the register port, with write, read
  and read-modify-write tasks.
  Assumes a slave that answers a read in the cycle after the strobe.
*/
`default_nettype none

module scr_host_model (
  input  wire logic       clk_sys,
  input  wire logic [7:0] regRdata,
  output var  logic [2:0] regAddr,
  output var  logic [7:0] regWdata,
  output var  logic       regWr,
  output var  logic       regRd
);
  timeunit 1ns;
  timeprecision 100ps;

  // ========================================================================
  // Idle bus at time zero
  initial begin
    regAddr  = 3'h0;
    regWdata = 8'h00;
    regWr    = 1'b0;
    regRd    = 1'b0;
  end

  // One-cycle write; offsets beyond the bank are never written
  task automatic wrReg(input logic [2:0] a, input logic [7:0] d);
    if (a <= 3'h3) begin
      @(posedge clk_sys);
      regAddr  <= a;
      regWdata <= d;
      regWr    <= 1'b1;
      @(posedge clk_sys);
      regWr    <= 1'b0;
    end
  endtask

  // One-cycle read; data taken in the answer cycle
  task automatic rdReg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk_sys);
    regRd   <= 1'b0;
    #1 d = regRdata;
  endtask

  // Reserved bits go back exactly as read
  task automatic rmwMeas(input logic [7:0] m, input logic [7:0] v);
    logic [7:0] d;
    rdReg(3'h0, d);
    wrReg(3'h0, (d & ~m) | v);
  endtask
endmodule

`default_nettype wire

// file: verif/scr_regs_tb.sv
/*
  Self-checking testbench of the sensor control register bank.
  Assumes scr_regs with a three-bit address so an unmapped offset exists.
*/
`default_nettype none

module scr_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic       clk_sys = 1'b0;
  logic       rst_n   = 1'b0;
  logic       supplyLowIn = 1'b0;
  logic [2:0] regAddr;
  logic [7:0] regWdata, regRdata, rd;
  logic       regWr, regRd, heaterOn, irq;
  logic [1:0] resolutionSelect;
  logic [3:0] rhWidth, tempWidth, heaterDrive;
  int         errors = 0;
  int         compares = 0;
  logic [3:0] rhTab[4]   = '{4'hC, 4'h8, 4'hA, 4'hB};
  logic [3:0] tempTab[4] = '{4'hE, 4'hC, 4'hD, 4'hB};
  logic [3:0] lvTab[6]   = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'hF};

  // ========================================================================
  // Clock of 25 ns
  always #12.5 clk_sys = ~clk_sys;

  scr_regs #(.ADDR_W(3)) scr_regs_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .supplyLowIn(supplyLowIn),
    .resolutionSelect(resolutionSelect), .rhWidth(rhWidth),
    .tempWidth(tempWidth), .heaterOn(heaterOn),
    .heaterDrive(heaterDrive), .irq(irq));

  scr_host_model scr_host_model_inst (
    .clk_sys(clk_sys), .regRdata(regRdata), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd));

  // ========================================================================
  // Compare, wait and verdict helpers
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rdChk(input string nm, input logic [2:0] a,
                       input logic [7:0] e);
    scr_host_model_inst.rdReg(a, rd);
    chk(nm, e, rd);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic close_out;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Watchdog well beyond the expected few hundred cycles
  initial begin
    #(4000 * 25);
    errors++;
    close_out();
  end

  // ========================================================================
  // Test sequence
  initial begin
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    settle(1);
    chk("widths", 8'hCE, {rhWidth, tempWidth});
    rdChk("meas", 3'h0, 8'h3A);
    rdChk("heater", 3'h1, 8'h00);
    rdChk("unmapped", 3'h4, 8'h00);
    // Every resolution code, with the read-only flag set and reserved bits written as zero
    for (int c = 0; c < 4; c++) begin
      scr_host_model_inst.wrReg(3'h0, {c[1], 1'b1, 5'h00, c[0]});
      settle(2);
      chk("res", {6'h00, c[1:0]}, {6'h00, resolutionSelect});
      chk("widths", {rhTab[c], tempTab[c]}, {rhWidth, tempWidth});
      rdChk("meas", 3'h0, 8'h3A | {c[1], 6'h00, c[0]});
    end
    // Heater levels, first disabled, then enabled
    foreach (lvTab[i]) begin
      scr_host_model_inst.wrReg(3'h1, {4'h0, lvTab[i]});
      scr_host_model_inst.rmwMeas(8'h04, 8'h00);
      settle(2);
      chk("drive off", 8'h00, {3'h0, heaterOn, heaterDrive});
      scr_host_model_inst.rmwMeas(8'h04, 8'h04);
      settle(2);
      chk("drive on", {4'h1, lvTab[i]}, {3'h0, heaterOn, heaterDrive});
      rdChk("heater", 3'h1, {4'h0, lvTab[i]});
    end
    // Supply-low event, interrupt raised, masked and cleared
    scr_host_model_inst.wrReg(3'h3, 8'h01);
    scr_host_model_inst.rdReg(3'h2, rd);
    @(posedge clk_sys) supplyLowIn <= 1'b1;
    settle(8);
    chk("irq", 8'h01, {7'h00, irq});
    rdChk("meas", 3'h0, 8'hFF);
    rdChk("status", 3'h2, 8'h01);
    settle(2);
    chk("irq", 8'h00, {7'h00, irq});
    scr_host_model_inst.rmwMeas(8'h04, 8'h00);
    settle(2);
    chk("irq masked", 8'h00, {7'h00, irq});
    scr_host_model_inst.wrReg(3'h3, 8'h02);
    settle(2);
    chk("irq", 8'h01, {7'h00, irq});
    rdChk("mask", 3'h3, 8'h02);
    rdChk("status", 3'h2, 8'h02);
    settle(2);
    chk("irq", 8'h00, {7'h00, irq});
    // Resolution change event, unmasked, back to the reset code
    scr_host_model_inst.wrReg(3'h3, 8'h04);
    scr_host_model_inst.rmwMeas(8'h81, 8'h00);
    settle(2);
    chk("widths", 8'hCE, {rhWidth, tempWidth});
    chk("irq", 8'h01, {7'h00, irq});
    rdChk("status", 3'h2, 8'h04);
    // Reset in mid-run restores the documented values
    @(posedge clk_sys) supplyLowIn <= 1'b0;
    @(posedge clk_sys) rst_n <= 1'b0;
    settle(3);
    @(posedge clk_sys) rst_n <= 1'b1;
    settle(1);
    rdChk("meas", 3'h0, 8'h3A);
    rdChk("heater", 3'h1, 8'h00);
    close_out();
  end
endmodule

`default_nettype wire
